//--- core/fpt_consts.vh
// Constants for the fan PWM and tachometer block: offsets, fields, resets, timing
`ifndef FPT_CONSTS_VH
`define FPT_CONSTS_VH

// Register byte addresses on the AXI4-Lite slave
`define FPT_ADDR_DUTY      4'h0
`define FPT_ADDR_STEP      4'h4
`define FPT_ADDR_DIVISOR   4'h8
`define FPT_ADDR_TACH      4'hc

// Fields of the fan duty control register
`define FPT_DUTY_FORCE_BIT 0
`define FPT_DUTY_LSB       1
`define FPT_DUTY_MSB       6
`define FPT_DUTY_WIDTH     6

// Tach status word: count in the low half, fresh flag above it
`define FPT_TACH_CNT_WIDTH 16
`define FPT_TACH_FRESH_BIT 16

// Reset values
`define FPT_RST_DUTY       8'h00
`define FPT_RST_STEP       16'h0021
`define FPT_RST_DIVISOR    8'h01

// Timing: clock period and tach base period, both in ns
`define FPT_CLK_PERIOD_NS  10
`define FPT_TACH_BASE_NS   30520
`define FPT_TACH_BASE_CYC  (`FPT_TACH_BASE_NS / `FPT_CLK_PERIOD_NS)

// AXI responses
`define FPT_RESP_OKAY      2'b00
`define FPT_RESP_SLVERR    2'b10

`endif

//--- core/fpt_tach.v
// Tachometer counter: divided count clock and period measurement between pulses
`timescale 1ns/1ps
`default_nettype none
`include "fpt_consts.vh"

module fpt_tach #(
    parameter BASE_CYC  = `FPT_TACH_BASE_CYC,
    parameter CNT_WIDTH = `FPT_TACH_CNT_WIDTH
) (
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst,
    // Fan side
    input  wire                 tach_in,
    // Settings and results
    input  wire [7:0]           tach_clock_divisor,
    input  wire                 fresh_clr,
    output reg  [CNT_WIDTH-1:0] tach_count_r,
    output reg                  tach_fresh_r
);

    reg  [12:0]          base_cnt_r;
    reg  [7:0]           div_cnt_r;
    reg                  tach_tick_r;
    reg                  tach_prev_r;
    reg  [CNT_WIDTH-1:0] period_cnt_r;
    wire                 base_tick;
    wire [7:0]           div_eff;
    wire                 tach_rise;

    assign base_tick = (base_cnt_r == BASE_CYC[12:0] - 13'd1);
    // A divisor of zero would stop the count clock, so it acts as one
    assign div_eff   = (tach_clock_divisor == 8'h00) ? 8'h01 : tach_clock_divisor;
    assign tach_rise = tach_in & ~tach_prev_r;

    // Count clock enable: 30.52 us times the divisor
    always @(posedge clk) begin
        if (rst) begin
            base_cnt_r  <= 13'd0;
            div_cnt_r   <= 8'h00;
            tach_tick_r <= 1'b0;
        end else begin
            tach_tick_r <= 1'b0;
            if (base_tick) begin
                base_cnt_r <= 13'd0;
                if (div_cnt_r >= div_eff - 8'h01) begin
                    div_cnt_r   <= 8'h00;
                    tach_tick_r <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
            end else begin
                base_cnt_r <= base_cnt_r + 13'd1;
            end
        end
    end

    // Measure count periods between rising edges; pulses are slow against the
    // count clock, so one edge per pulse is seen without a filter
    always @(posedge clk) begin
        if (rst) begin
            tach_prev_r  <= 1'b0;
            period_cnt_r <= {CNT_WIDTH{1'b0}};
            tach_count_r <= {CNT_WIDTH{1'b0}};
            tach_fresh_r <= 1'b0;
        end else begin
            tach_prev_r <= tach_in;
            if (tach_rise) begin
                tach_count_r <= period_cnt_r;
                period_cnt_r <= {CNT_WIDTH{1'b0}};
            end else if (tach_tick_r && period_cnt_r != {CNT_WIDTH{1'b1}}) begin
                period_cnt_r <= period_cnt_r + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
            // A new sample beats a clear in the same cycle
            if (tach_rise)
                tach_fresh_r <= 1'b1;
            else if (fresh_clr)
                tach_fresh_r <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- core/fpt_top.v
// Fan PWM generator and tachometer counter with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "fpt_consts.vh"

// Summary of operation
// - Force bit clear: duty cycle comes from bits six down to one.
// - Duty zero with force clear keeps the fan drive output low.
// - Nonzero duty gives 1.56% to 98.44% in sixty-fourths of the period.
// - Period programmable 0.00064 to 41.94 ms, within two percent.
// - High time ranges from 0.00001 ms to 41.29 ms.
// - Tach count clock period is 30.52 us times the divisor.
module fpt_top #(
    parameter TACH_CNT_WIDTH = `FPT_TACH_CNT_WIDTH
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // AXI4-Lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Fan pins
    output reg         fan_drive_output,
    input  wire        tach_in
);

    // Software registers
    reg  [7:0]                fan_duty_control_r;
    reg  [15:0]               pwm_step_div_r;
    reg  [7:0]                tach_clock_divisor_r;

    // Write channel capture
    reg                       aw_got_r;
    reg                       w_got_r;
    reg  [3:0]                aw_addr_r;
    reg  [31:0]               w_data_r;
    reg  [3:0]                w_strb_r;
    wire                      wr_fire;
    wire                      aw_hs;
    wire                      w_hs;
    wire                      ar_hs;

    // PWM state
    reg  [15:0]               step_cnt_r;
    reg  [5:0]                phase_r;
    reg  [5:0]                duty_act_r;
    reg                       force_act_r;
    wire                      step_tick;
    wire [5:0]                duty_field;
    wire                      force_bit;
    reg                       pwm_nxt;

    // Tach results
    wire [TACH_CNT_WIDTH-1:0] tach_count;
    wire                      tach_fresh;
    wire                      fresh_clr;

    assign aw_hs   = s_axi_awvalid & s_axi_awready;
    assign w_hs    = s_axi_wvalid & s_axi_wready;
    assign ar_hs   = s_axi_arvalid & s_axi_arready;
    assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;

    // Each channel is refused only while its own item waits or a response is out
    assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // Capture address and data in either order
    always @(posedge clk) begin
        if (rst) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_r <= 1'b0;
            end
            if (w_hs) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_r <= 1'b0;
            end
        end
    end

    // Register writes and write response
    always @(posedge clk) begin
        if (rst) begin
            fan_duty_control_r   <= `FPT_RST_DUTY;
            pwm_step_div_r       <= `FPT_RST_STEP;
            tach_clock_divisor_r <= `FPT_RST_DIVISOR;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= `FPT_RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `FPT_RESP_OKAY;
                case (aw_addr_r & 4'hc)
                    `FPT_ADDR_DUTY: begin
                        if (w_strb_r[0])
                            fan_duty_control_r <= w_data_r[7:0];
                    end
                    `FPT_ADDR_STEP: begin
                        if (w_strb_r[0])
                            pwm_step_div_r[7:0] <= w_data_r[7:0];
                        if (w_strb_r[1])
                            pwm_step_div_r[15:8] <= w_data_r[15:8];
                    end
                    `FPT_ADDR_DIVISOR: begin
                        if (w_strb_r[0])
                            tach_clock_divisor_r <= w_data_r[7:0];
                    end
                    `FPT_ADDR_TACH: begin
                        // Read-only status; writes are accepted and ignored
                    end
                    default: begin
                        s_axi_bresp <= `FPT_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Reading the tach word takes away its fresh flag
    assign fresh_clr = ar_hs && ((s_axi_araddr & 4'hc) == `FPT_ADDR_TACH);

    // Read data path, answered one cycle after the address is taken
    always @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `FPT_RESP_OKAY;
        end else begin
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `FPT_RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                case (s_axi_araddr & 4'hc)
                    `FPT_ADDR_DUTY:
                        s_axi_rdata[7:0] <= fan_duty_control_r;
                    `FPT_ADDR_STEP:
                        s_axi_rdata[15:0] <= pwm_step_div_r;
                    `FPT_ADDR_DIVISOR:
                        s_axi_rdata[7:0] <= tach_clock_divisor_r;
                    `FPT_ADDR_TACH: begin
                        s_axi_rdata[TACH_CNT_WIDTH-1:0] <= tach_count;
                        s_axi_rdata[`FPT_TACH_FRESH_BIT] <= tach_fresh;
                    end
                    default:
                        s_axi_rresp <= `FPT_RESP_SLVERR;
                endcase
            end
        end
    end

    // Duty field and force bit as software wrote them
    assign force_bit  = fan_duty_control_r[`FPT_DUTY_FORCE_BIT];
    assign duty_field = fan_duty_control_r[`FPT_DUTY_MSB:`FPT_DUTY_LSB];

    // Step divider: one period is 64 steps of (step_div + 1) clocks, so a
    // divisor of 32 gives about 0.021 ms and 62499 gives 40 ms; the period
    // is set by the clock crystal, well inside two percent
    assign step_tick = (step_cnt_r >= pwm_step_div_r);

    always @(posedge clk) begin
        if (rst) begin
            step_cnt_r  <= 16'h0000;
            phase_r     <= 6'h00;
            duty_act_r  <= 6'h00;
            force_act_r <= 1'b0;
        end else begin
            if (step_tick) begin
                step_cnt_r <= 16'h0000;
                phase_r    <= phase_r + 6'h01;
                // New duty and force settings take effect at the period boundary so that a
                // change of them mid-period never gives a runt or a stretched pulse; the step
                // divisor is not held back and applies at once
                if (phase_r == 6'h3f) begin
                    duty_act_r  <= duty_field;
                    force_act_r <= force_bit;
                end
            end else begin
                step_cnt_r <= step_cnt_r + 16'h0001;
            end
        end
    end

    // Output decision; force wins, duty zero gives a steady low
    always @* begin
        if (force_act_r)
            pwm_nxt = 1'b1;
        else if (duty_act_r == 6'h00)
            pwm_nxt = 1'b0;
        else
            pwm_nxt = (phase_r < duty_act_r);
    end

    // Registered pin drive, low from reset
    always @(posedge clk) begin
        if (rst)
            fan_drive_output <= 1'b0;
        else
            fan_drive_output <= pwm_nxt;
    end

    // Tachometer measurement
    fpt_tach #(
        .BASE_CYC  (`FPT_TACH_BASE_CYC),
        .CNT_WIDTH (TACH_CNT_WIDTH)
    ) u_tach (
        .clk                (clk),
        .rst                (rst),
        .tach_in            (tach_in),
        .tach_clock_divisor (tach_clock_divisor_r),
        .fresh_clr          (fresh_clr),
        .tach_count_r       (tach_count),
        .tach_fresh_r       (tach_fresh)
    );

endmodule
`default_nettype wire

//--- verif/fpt_fan_model.sv
// Fan model: tach pulse train with set high and low times
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_model (
    // Clock and control
    input  wire logic        clk,
    input  wire logic        spin,
    input  wire logic [31:0] hi_cyc,
    input  wire logic [31:0] lo_cyc,
    // Tach pin
    output var  logic        tach_out
);
    logic [31:0] cnt_r = 32'h0;
    initial tach_out = 1'b0;
    // One pulse per half turn; bench picks phases of at least three and one counts
    always @(posedge clk) begin
        if (!spin) begin
            cnt_r <= 32'h0;
            tach_out <= 1'b0;
        end else begin
            cnt_r <= (cnt_r + 1 >= hi_cyc + lo_cyc) ? 32'h0 : cnt_r + 1;
            tach_out <= cnt_r < hi_cyc;
        end
    end
endmodule
`default_nettype wire

//--- verif/fpt_top_bench.sv
// Bench for the fan PWM and tachometer block
`timescale 1ns/1ps
`default_nettype none
module fpt_top_bench;
    localparam int TICK = 3052; // Count clock base, in clk cycles
    logic        clk = 1'b0, rst = 1'b1, spin = 1'b0, tach_in, fan_drive_output;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, hi_cyc = 3 * TICK, lo_cyc = 2 * TICK;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          bad_count = 0, checked = 0, cyc = 0;
    fpt_top fpt_top_i (.clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .fan_drive_output, .tach_in);
    fpt_fan_model fpt_fan_model_i (.clk, .spin, .hi_cyc, .lo_cyc, .tach_out(tach_in));
    // 100 MHz clock
    always #5 clk = ~clk;
    task automatic report_and_stop();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        chk(s_axi_bresp, 32'h0); // Every mapped word answers OKAY
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        logic tr, tv;
        tv = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tv) begin
            @(negedge clk);
            tr = s_axi_arvalid && s_axi_arready;
            tv = s_axi_rvalid;
            v = s_axi_rdata;
            @(posedge clk);
            if (tr) s_axi_arvalid <= 1'b0;
        end
        chk(s_axi_rresp, 32'h0); // Every mapped word answers OKAY
        s_axi_rready <= 1'b0;
    endtask
    task automatic fresh(output logic [31:0] v);
        do rd(4'hc, v); while (v[16] !== 1'b1);
    endtask
    // Program duty and step, let the change settle, then count high cycles over 4 periods
    task automatic pwm(input logic [7:0] duty, input logic [15:0] step);
        int p, e, hi;
        p = 64 * (int'(step) + 1);
        e = duty[0] ? p : int'(duty[6:1]) * (int'(step) + 1);
        hi = 0;
        wr(4'h0, {24'h0, duty});
        wr(4'h4, {16'h0, step});
        rd(4'h0, d);
        chk(d, {24'h0, duty});
        repeat (2200 + 3 * p) @(posedge clk);
        repeat (4 * p) begin
            @(negedge clk);
            hi += (fan_drive_output === 1'b1);
        end
        chk(hi, 4 * e);
    endtask
    // Cycle ceiling a little above the planned run of about 80k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4), d);
            chk(d, i == 1 ? 32'h21 : i == 2 ? 32'h1 : 32'h0);
        end
        chk(fan_drive_output, 1'b0);
        wr(4'hc, 32'h1234);
        rd(4'hc, d);
        chk(d, 32'h0);
        $display("done: reset values");
        spin <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            pwm(i == 0 ? 8'h00 : i == 1 ? 8'h02 : i == 2 ? 8'h40 : i == 3 ? 8'h7e :
                i == 4 ? 8'h7f : i == 5 ? 8'h01 : 8'hc0, i == 6 ? 16'h1 : 16'h0);
        end
        $display("done: drive waveform");
        rd(4'hc, d);
        fresh(d);
        chk(d[15:0] >= 16'h4 && d[15:0] <= 16'h6, 1'b1);
        rd(4'hc, d);
        chk(d[16], 1'b0);
        wr(4'h8, 32'h2);
        hi_cyc <= 6 * TICK;
        lo_cyc <= 2 * TICK;
        fresh(d);
        fresh(d);
        chk(d[15:0] >= 16'h3 && d[15:0] <= 16'h5, 1'b1);
        $display("done: tach count");
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- verif/fpt_top_chk.sv
// Checker: bus handshakes and fan drive waveform
`timescale 1ns/1ps
`default_nettype none
module fpt_top_chk #(parameter TACH_CNT_WIDTH = 16) (
    // Clock, reset
    input wire logic        clk,
    input wire logic        rst,
    // Register bus
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Fan pin
    input wire logic        fan_drive_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0]  adr_r;
    logic [31:0] dat_r;
    logic [7:0]  duty_r;
    logic [15:0] step_r;
    int          settle_r, hi_r, rise_r, per;
    logic        ok;
    // Settled once an old period (up to the reset one) and three new ones have passed
    assign per = 64 * (int'(step_r) + 1);
    assign ok = settle_r > 3 * per + 2204;
    // Shadow of the settings; assumes full-word writes, which keeps it small
    always_ff @(posedge clk) begin
        if (s_axi_awvalid && s_axi_awready) adr_r <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) dat_r <= s_axi_wdata;
        hi_r <= fan_drive_output ? hi_r + 1 : 0;
        rise_r <= $rose(fan_drive_output) ? 1 : rise_r + 1;
        settle_r <= settle_r + 1;
        if (s_axi_bvalid && s_axi_bready) begin
            settle_r <= 0;
            if (adr_r[3:2] == 2'h0) duty_r <= dat_r[7:0];
            if (adr_r[3:2] == 2'h1) step_r <= dat_r[15:0];
        end
        if (rst) begin
            duty_r <= 8'h00;
            step_r <= 16'h0021;
            settle_r <= 0;
        end
    end
    property p_force; ok && duty_r[0] |-> fan_drive_output; endproperty
    a_force: assert property (p_force) else $error("drive low while forced");
    property p_zero; ok && duty_r[6:0] == 7'h00 |-> !fan_drive_output; endproperty
    a_zero: assert property (p_zero) else $error("drive high at zero duty");
    property p_high; ok && !duty_r[0] && $fell(fan_drive_output)
        |-> hi_r == int'(duty_r[6:1]) * (int'(step_r) + 1); endproperty
    a_high: assert property (p_high) else $error("wrong high time");
    property p_period; ok && !duty_r[0] && duty_r[6:1] != 6'h00
        && $rose(fan_drive_output) |-> rise_r == per; endproperty
    a_period: assert property (p_period) else $error("wrong drive period");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_rd_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd_end: assert property (p_rd_end) else $error("read answer repeated");
    property p_wr_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_wr_end: assert property (p_wr_end) else $error("write answer repeated");
    property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write taken during answer");
endmodule
bind fpt_top fpt_top_chk #(.TACH_CNT_WIDTH(TACH_CNT_WIDTH)) fpt_top_chk_i (.clk, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .fan_drive_output);
`default_nettype wire
